// ==== rtl/dcq_map.sv ====
// Quick channel mapping, channel queue steering and queue to controller paths
`timescale 1ns/1ps
`default_nettype none
module dcq_map #(
   parameter int NUM_QCH   = dcq_pkg::NUM_QCH,
   parameter int NUM_DMACH = dcq_pkg::NUM_DMACH,
   parameter int REQ_W     = dcq_pkg::REQ_W
) (
   input  wire logic                            CLK,
   input  wire logic                            RESET,
   // APB slave
   input  wire logic                            PSEL,
   input  wire logic                            PENABLE,
   input  wire logic                            PWRITE,
   input  wire logic [dcq_pkg::ADDR_W-1:0]      PADDR,
   input  wire logic [dcq_pkg::DATA_W-1:0]      PWDATA,
   output logic      [dcq_pkg::DATA_W-1:0]      PRDATA,
   output logic                                 PREADY,
   output logic                                 PSLVERR,
   // Parameter RAM write watch
   input  wire logic                            PRAM_WR_VALID,
   input  wire logic [dcq_pkg::PRAM_ADDR_W-1:0] PRAM_WR_ADDR,
   output logic      [NUM_QCH-1:0]              QUICK_EVENT,
   // Channel events and their queue placement
   input  wire logic [NUM_DMACH-1:0]            DMA_EVENT,
   output logic      [NUM_DMACH-1:0]            QUEUE_ZERO_DMA_EVENT,
   output logic      [NUM_DMACH-1:0]            QUEUE_ONE_DMA_EVENT,
   output logic      [NUM_QCH-1:0]              QUEUE_ZERO_QUICK_EVENT,
   output logic      [NUM_QCH-1:0]              QUEUE_ONE_QUICK_EVENT,
   // Event queue zero to transfer controller zero
   input  wire logic                            QUEUE_ZERO_REQ_VALID,
   input  wire logic [REQ_W-1:0]                QUEUE_ZERO_REQ_DATA,
   output logic                                 QUEUE_ZERO_REQ_READY,
   output logic                                 CTRL_ZERO_REQ_VALID,
   output logic      [REQ_W-1:0]                CTRL_ZERO_REQ_DATA,
   input  wire logic                            CTRL_ZERO_REQ_READY,
   // Event queue one to transfer controller one
   input  wire logic                            QUEUE_ONE_REQ_VALID,
   input  wire logic [REQ_W-1:0]                QUEUE_ONE_REQ_DATA,
   output logic                                 QUEUE_ONE_REQ_READY,
   output logic                                 CTRL_ONE_REQ_VALID,
   output logic      [REQ_W-1:0]                CTRL_ONE_REQ_DATA,
   input  wire logic                            CTRL_ONE_REQ_READY
);

   localparam int NUM_DQREG = NUM_DMACH / dcq_pkg::FLD_PER_REG;

   // Elaboration checks
   if (NUM_QCH < 1 || NUM_QCH > dcq_pkg::FLD_PER_REG)
   begin : g_bad_qch
      $error("NUM_QCH must be 1 to 8");
   end
   if (NUM_DMACH < dcq_pkg::FLD_PER_REG || NUM_DMACH > dcq_pkg::NUM_DMACH
       || (NUM_DMACH % dcq_pkg::FLD_PER_REG) != 0)
   begin : g_bad_dmach
      $error("NUM_DMACH must be a multiple of 8 up to 64");
   end
   if (REQ_W < 1)
   begin : g_bad_req
      $error("REQ_W must be positive");
   end

   // Package layout checks
   if (dcq_pkg::PRAM_SET_W > dcq_pkg::PSET_W)
   begin : g_bad_set_w
      $error("parameter RAM set address wider than the pointer field");
   end
   if (dcq_pkg::PSET_LSB + dcq_pkg::PSET_W > dcq_pkg::DATA_W)
   begin : g_bad_pset
      $error("pointer field does not fit the map word");
   end
   if (dcq_pkg::QMAP_WMASK[dcq_pkg::PSET_LSB +: dcq_pkg::PSET_W] != '1
       || dcq_pkg::QMAP_WMASK[dcq_pkg::TWORD_LSB +: dcq_pkg::TWORD_W] != '1)
   begin : g_bad_mask
      $error("map write mask must cover pointer and trigger word fields");
   end
   if (dcq_pkg::QF_W > dcq_pkg::QF_STRIDE
       || dcq_pkg::FLD_PER_REG * dcq_pkg::QF_STRIDE > dcq_pkg::DATA_W)
   begin : g_bad_qfield
      $error("queue fields do not fit the select word");
   end
   if ((dcq_pkg::QMAP_BASE >> 2) + NUM_QCH > (dcq_pkg::DQSEL_BASE >> 2)
       || (dcq_pkg::DQSEL_BASE >> 2) + NUM_DQREG > (dcq_pkg::QQSEL_OFS >> 2))
   begin : g_bad_map
      $error("register groups overlap");
   end

   // Register storage
   logic [dcq_pkg::DATA_W-1:0] qmap_r  [NUM_QCH];
   logic [dcq_pkg::DATA_W-1:0] dqsel_r [NUM_DQREG];
   logic [dcq_pkg::DATA_W-1:0] qqsel_r;

   logic [dcq_pkg::DATA_W-1:0] prdata_r;
   logic [dcq_pkg::DATA_W-1:0] prdata_nxt;
   logic                       pslverr_r;
   logic                       pslverr_nxt;

   dcq_pkg::dcq_reg_e          acc_kind;
   logic [2:0]                 acc_idx;
   logic                       apb_setup;
   logic                       apb_wr;
   logic                       wr_qmap;
   logic                       wr_dqsel;
   logic                       wr_qqsel;

   // Routing state
   logic [NUM_QCH-1:0]         trig_hit;
   logic [NUM_QCH-1:0]         quick_event_r;
   logic [NUM_DMACH-1:0]       q0_dma_r;
   logic [NUM_DMACH-1:0]       q1_dma_r;
   logic [NUM_DMACH-1:0]       q0_dma_nxt;
   logic [NUM_DMACH-1:0]       q1_dma_nxt;
   logic [NUM_QCH-1:0]         q0_quick_r;
   logic [NUM_QCH-1:0]         q1_quick_r;
   logic [NUM_QCH-1:0]         q0_quick_nxt;
   logic [NUM_QCH-1:0]         q1_quick_nxt;

   // Address decode
   function automatic dcq_pkg::dcq_reg_e decode_kind(input logic [dcq_pkg::ADDR_W-1:0] a,
                                                      input int nq,
                                                      input int nd);
      logic [dcq_pkg::ADDR_W-1:0] word_ofs;
      word_ofs    = a >> 2;
      decode_kind = dcq_pkg::DCQ_REG_NONE;
      if (a[1:0] != 2'h0)
         decode_kind = dcq_pkg::DCQ_REG_NONE;
      else if (a >= dcq_pkg::QMAP_BASE
               && word_ofs < (dcq_pkg::QMAP_BASE >> 2) + nq[dcq_pkg::ADDR_W-1:0])
         decode_kind = dcq_pkg::DCQ_REG_QMAP;
      else if (a >= dcq_pkg::DQSEL_BASE
               && word_ofs < (dcq_pkg::DQSEL_BASE >> 2) + nd[dcq_pkg::ADDR_W-1:0])
         decode_kind = dcq_pkg::DCQ_REG_DQSEL;
      else if (a == dcq_pkg::QQSEL_OFS)
         decode_kind = dcq_pkg::DCQ_REG_QQSEL;
   endfunction : decode_kind

   // Event passes only when its queue field names this queue
   function automatic logic steer(input logic                     ev,
                                  input logic [dcq_pkg::QF_W-1:0] sel,
                                  input logic [dcq_pkg::QF_W-1:0] q_id);
      steer = ev && (sel == q_id);
   endfunction : steer

   assign acc_kind  = decode_kind(PADDR, NUM_QCH, NUM_DQREG);
   assign acc_idx   = PADDR[4:2];
   assign apb_setup = PSEL && !PENABLE;
   assign apb_wr    = PSEL && PENABLE && PWRITE;

   // Write strobes, one per register group
   assign wr_qmap   = apb_wr && acc_kind == dcq_pkg::DCQ_REG_QMAP;
   assign wr_dqsel  = apb_wr && acc_kind == dcq_pkg::DCQ_REG_DQSEL;
   assign wr_qqsel  = apb_wr && acc_kind == dcq_pkg::DCQ_REG_QQSEL;

   // Zero wait state slave
   assign PREADY  = 1'b1;
   assign PRDATA  = prdata_r;
   assign PSLVERR = pslverr_r;

   // Quick channel map registers
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         for (int q = 0; q < NUM_QCH; q++)
            qmap_r[q] <= dcq_pkg::QMAP_RST;
      end
      else if (wr_qmap)
      begin
         qmap_r[acc_idx] <= PWDATA & dcq_pkg::QMAP_WMASK;
      end
   end

   // Channel queue select registers
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         for (int r = 0; r < NUM_DQREG; r++)
            dqsel_r[r] <= dcq_pkg::DQSEL_RST;
      end
      else if (wr_dqsel)
      begin
         dqsel_r[acc_idx] <= PWDATA & dcq_pkg::QSEL_WMASK;
      end
   end

   // Quick channel queue select register
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         qqsel_r <= dcq_pkg::QQSEL_RST;
      else if (wr_qqsel)
         qqsel_r <= PWDATA & dcq_pkg::QSEL_WMASK;
   end

   // Read data and error, sampled in the setup cycle
   always_comb
   begin
      prdata_nxt  = '0;
      pslverr_nxt = 1'b0;
      case (acc_kind)
         dcq_pkg::DCQ_REG_QMAP:
         begin
            prdata_nxt = qmap_r[acc_idx];
         end
         dcq_pkg::DCQ_REG_DQSEL:
         begin
            prdata_nxt = dqsel_r[acc_idx];
         end
         dcq_pkg::DCQ_REG_QQSEL:
         begin
            prdata_nxt = qqsel_r;
         end
         default:
         begin
            pslverr_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         prdata_r <= '0;
      else if (apb_setup)
         prdata_r <= PWRITE ? '0 : prdata_nxt;
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         pslverr_r <= 1'b0;
      else if (apb_setup)
         pslverr_r <= pslverr_nxt;
   end

   // Trigger word detection for every quick channel
   dcq_trig_match #(
      .NUM_QCH (NUM_QCH)
   ) u_trig (
      .map_word (qmap_r),
      .wr_valid (PRAM_WR_VALID),
      .wr_addr  (PRAM_WR_ADDR),
      .hit      (trig_hit)
   );

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         quick_event_r <= '0;
      else
         quick_event_r <= trig_hit;
   end

   assign QUICK_EVENT = quick_event_r;

   // Channel event steering
   always_comb
   begin
      logic [dcq_pkg::QF_W-1:0] sel;
      sel        = dcq_pkg::QUEUE_ZERO;
      q0_dma_nxt = '0;
      q1_dma_nxt = '0;
      for (int c = 0; c < NUM_DMACH; c++)
      begin
         sel = dcq_pkg::queue_field(dqsel_r[c / dcq_pkg::FLD_PER_REG],
                                    c % dcq_pkg::FLD_PER_REG);
         q0_dma_nxt[c] = steer(DMA_EVENT[c], sel, dcq_pkg::QUEUE_ZERO);
         q1_dma_nxt[c] = steer(DMA_EVENT[c], sel, dcq_pkg::QUEUE_ONE);
      end
   end

   // Quick event steering
   always_comb
   begin
      logic [dcq_pkg::QF_W-1:0] sel;
      sel          = dcq_pkg::QUEUE_ZERO;
      q0_quick_nxt = '0;
      q1_quick_nxt = '0;
      for (int q = 0; q < NUM_QCH; q++)
      begin
         sel = dcq_pkg::queue_field(qqsel_r, q);
         q0_quick_nxt[q] = steer(trig_hit[q], sel, dcq_pkg::QUEUE_ZERO);
         q1_quick_nxt[q] = steer(trig_hit[q], sel, dcq_pkg::QUEUE_ONE);
      end
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         q0_dma_r <= '0;
         q1_dma_r <= '0;
      end
      else
      begin
         q0_dma_r <= q0_dma_nxt;
         q1_dma_r <= q1_dma_nxt;
      end
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         q0_quick_r <= '0;
         q1_quick_r <= '0;
      end
      else
      begin
         q0_quick_r <= q0_quick_nxt;
         q1_quick_r <= q1_quick_nxt;
      end
   end

   assign QUEUE_ZERO_DMA_EVENT   = q0_dma_r;
   assign QUEUE_ONE_DMA_EVENT    = q1_dma_r;
   assign QUEUE_ZERO_QUICK_EVENT = q0_quick_r;
   assign QUEUE_ONE_QUICK_EVENT  = q1_quick_r;

   // Fixed queue to controller paths
   dcq_req_port #(
      .REQ_W (REQ_W)
   ) u_port_zero (
      .clk       (CLK),
      .reset     (RESET),
      .in_valid  (QUEUE_ZERO_REQ_VALID),
      .in_data   (QUEUE_ZERO_REQ_DATA),
      .in_ready  (QUEUE_ZERO_REQ_READY),
      .out_valid (CTRL_ZERO_REQ_VALID),
      .out_data  (CTRL_ZERO_REQ_DATA),
      .out_ready (CTRL_ZERO_REQ_READY)
   );

   dcq_req_port #(
      .REQ_W (REQ_W)
   ) u_port_one (
      .clk       (CLK),
      .reset     (RESET),
      .in_valid  (QUEUE_ONE_REQ_VALID),
      .in_data   (QUEUE_ONE_REQ_DATA),
      .in_ready  (QUEUE_ONE_REQ_READY),
      .out_valid (CTRL_ONE_REQ_VALID),
      .out_data  (CTRL_ONE_REQ_DATA),
      .out_ready (CTRL_ONE_REQ_READY)
   );

endmodule : dcq_map
`default_nettype wire

// ==== rtl/dcq_pkg.sv ====
// Constants and helpers for the DMA channel and queue mapping block
//
// Behaviour
// - Quick channel map bits 13:5 pick the parameter set; 80h-1FFh reserved
// - Map bits 4:2 pick trigger word; writing that word raises quick event
// - Quick channel maps reset to parameter set 0, all fields zero
// - Each of 64 DMA channels sends its event to its chosen queue
// - Every DMA channel selects queue 0 after reset
// - Queue select register n: eight 3-bit fields, field k is channel 8n+k
// - Queue field value 0 means queue 0, 1 means queue 1, others reserved
// - Queue 0 feeds controller 0, queue 1 feeds controller 1 only
// - Quick queue select: field k at bits 4k+2:4k, 0 and 1 valid
package dcq_pkg;

   localparam int ADDR_W       = 12;
   localparam int DATA_W       = 32;
   localparam int NUM_QCH      = 8;
   localparam int NUM_DMACH    = 64;
   localparam int FLD_PER_REG  = 8;
   localparam int REQ_W        = 32;

   localparam logic [ADDR_W-1:0] QMAP_BASE  = 12'h000;
   localparam logic [ADDR_W-1:0] DQSEL_BASE = 12'h020;
   localparam logic [ADDR_W-1:0] QQSEL_OFS  = 12'h040;

   localparam int PSET_LSB     = 5;
   localparam int PSET_W       = 9;
   localparam int TWORD_LSB    = 2;
   localparam int TWORD_W      = 3;
   localparam int PRAM_SET_W   = 7;
   localparam int PRAM_ADDR_W  = PRAM_SET_W + TWORD_W;
   localparam int QF_W         = 3;
   localparam int QF_STRIDE    = 4;

   localparam logic [DATA_W-1:0] QMAP_RST   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DQSEL_RST  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] QQSEL_RST  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] QMAP_WMASK = 32'h0000_3ffc;
   localparam logic [DATA_W-1:0] QSEL_WMASK = 32'h7777_7777;

   localparam logic [QF_W-1:0] QUEUE_ZERO = 3'h0;
   localparam logic [QF_W-1:0] QUEUE_ONE  = 3'h1;

   typedef enum {DCQ_REG_QMAP, DCQ_REG_DQSEL, DCQ_REG_QQSEL, DCQ_REG_NONE} dcq_reg_e;

   // Queue field k of a queue select word
   function automatic logic [QF_W-1:0] queue_field(input logic [DATA_W-1:0] word,
                                                   input int k);
      queue_field = word[k*QF_STRIDE +: QF_W];
   endfunction : queue_field

endpackage : dcq_pkg

// ==== rtl/dcq_req_port.sv ====
// One-deep registered stage from an event queue to its transfer controller
`timescale 1ns/1ps
`default_nettype none
module dcq_req_port #(
   parameter int REQ_W = 32
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   input  wire logic [REQ_W-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [REQ_W-1:0] out_data,
   input  wire logic             out_ready
);

   logic             valid_r;
   logic [REQ_W-1:0] data_r;

   assign in_ready  = !valid_r || out_ready;
   assign out_valid = valid_r;
   assign out_data  = data_r;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         valid_r <= 1'b0;
      else if (in_ready)
         valid_r <= in_valid;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         data_r <= '0;
      else if (in_ready && in_valid)
         data_r <= in_data;
   end

endmodule : dcq_req_port
`default_nettype wire

// ==== rtl/dcq_trig_match.sv ====
// Parameter write trigger matcher for all quick channels
`timescale 1ns/1ps
`default_nettype none
module dcq_trig_match #(
   parameter int NUM_QCH = 8
) (
   input  wire logic [dcq_pkg::DATA_W-1:0]      map_word [NUM_QCH],
   input  wire logic                            wr_valid,
   input  wire logic [dcq_pkg::PRAM_ADDR_W-1:0] wr_addr,
   output logic      [NUM_QCH-1:0]              hit
);

   logic [dcq_pkg::PSET_W-1:0]  wr_set;
   logic [dcq_pkg::TWORD_W-1:0] wr_word;

   assign wr_set  = {{(dcq_pkg::PSET_W-dcq_pkg::PRAM_SET_W){1'b0}},
                     wr_addr[dcq_pkg::PRAM_ADDR_W-1:dcq_pkg::TWORD_W]};
   assign wr_word = wr_addr[dcq_pkg::TWORD_W-1:0];

   always_comb
   begin
      for (int q = 0; q < NUM_QCH; q++)
      begin
         hit[q] = wr_valid
            && (map_word[q][dcq_pkg::PSET_LSB +: dcq_pkg::PSET_W] == wr_set)
            && (map_word[q][dcq_pkg::TWORD_LSB +: dcq_pkg::TWORD_W] == wr_word);
      end
   end

endmodule : dcq_trig_match
`default_nettype wire

// ==== verif/dcq_map_chk.sv ====
// Port assertions for the mapping block
`timescale 1ns/1ps
`default_nettype none
module dcq_map_chk #(
   parameter int NUM_QCH   = 8,
   parameter int NUM_DMACH = 64,
   parameter int REQ_W     = 32
) (
   input wire logic                 CLK,
   input wire logic                 RESET,
   input wire logic                 PSEL,
   input wire logic                 PENABLE,
   input wire logic                 PWRITE,
   input wire logic [11:0]          PADDR,
   input wire logic [31:0]          PRDATA,
   input wire logic                 PSLVERR,
   input wire logic                 PRAM_WR_VALID,
   input wire logic [NUM_QCH-1:0]   QUICK_EVENT,
   input wire logic [NUM_QCH-1:0]   QUEUE_ZERO_QUICK_EVENT,
   input wire logic [NUM_QCH-1:0]   QUEUE_ONE_QUICK_EVENT,
   input wire logic [NUM_DMACH-1:0] DMA_EVENT,
   input wire logic [NUM_DMACH-1:0] QUEUE_ZERO_DMA_EVENT,
   input wire logic [NUM_DMACH-1:0] QUEUE_ONE_DMA_EVENT,
   input wire logic                 QUEUE_ZERO_REQ_VALID,
   input wire logic [REQ_W-1:0]     QUEUE_ZERO_REQ_DATA,
   input wire logic                 QUEUE_ZERO_REQ_READY,
   input wire logic                 CTRL_ZERO_REQ_VALID,
   input wire logic [REQ_W-1:0]     CTRL_ZERO_REQ_DATA,
   input wire logic                 CTRL_ZERO_REQ_READY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   trig_write_a: assert property (!PRAM_WR_VALID |=> QUICK_EVENT == '0)
      else $error("quick event with no parameter write");
   quick_split_a: assert property ((QUEUE_ZERO_QUICK_EVENT & QUEUE_ONE_QUICK_EVENT) == '0
      && ((QUEUE_ZERO_QUICK_EVENT | QUEUE_ONE_QUICK_EVENT) & ~QUICK_EVENT) == '0)
      else $error("quick event steering wrong");
   dma_split_a: assert property ((QUEUE_ZERO_DMA_EVENT & QUEUE_ONE_DMA_EVENT) == '0)
      else $error("channel event on both queues");
   dma_cause_a: assert property (((QUEUE_ZERO_DMA_EVENT | QUEUE_ONE_DMA_EVENT)
      & ~$past(DMA_EVENT)) == '0)
      else $error("queued event with no channel event");
   req_take_a: assert property (QUEUE_ZERO_REQ_VALID && QUEUE_ZERO_REQ_READY |=>
      CTRL_ZERO_REQ_VALID && CTRL_ZERO_REQ_DATA == $past(QUEUE_ZERO_REQ_DATA))
      else $error("request not passed to controller");
   req_hold_a: assert property (CTRL_ZERO_REQ_VALID && !CTRL_ZERO_REQ_READY |=>
      CTRL_ZERO_REQ_VALID && $stable(CTRL_ZERO_REQ_DATA))
      else $error("stalled request not held");
   bad_addr_a: assert property (PSEL && !PENABLE && PADDR > 12'h040 |=>
      PSLVERR && PRDATA == '0)
      else $error("unmapped access not refused");
   map_rsv_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR < 12'h020 |=>
      (PRDATA & 32'hffff_c003) == '0)
      else $error("reserved map bits not zero");
   cover property (PRAM_WR_VALID ##1 QUICK_EVENT == '1);
   cover property (CTRL_ZERO_REQ_VALID && !CTRL_ZERO_REQ_READY);
   cover property (PSEL && PENABLE && PSLVERR);
endmodule : dcq_map_chk
bind dcq_map dcq_map_chk #(.NUM_QCH(NUM_QCH), .NUM_DMACH(NUM_DMACH), .REQ_W(REQ_W))
   dcq_map_chk_inst (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PSLVERR,
   .PRAM_WR_VALID, .QUICK_EVENT, .QUEUE_ZERO_QUICK_EVENT, .QUEUE_ONE_QUICK_EVENT, .DMA_EVENT,
   .QUEUE_ZERO_DMA_EVENT, .QUEUE_ONE_DMA_EVENT, .QUEUE_ZERO_REQ_VALID, .QUEUE_ZERO_REQ_DATA,
   .QUEUE_ZERO_REQ_READY, .CTRL_ZERO_REQ_VALID, .CTRL_ZERO_REQ_DATA, .CTRL_ZERO_REQ_READY);
`default_nettype wire

// ==== verif/dcq_map_test.sv ====
// Randomised self-checking bench for the mapping block
`timescale 1ns/1ps
`default_nettype none
module dcq_map_test;
   logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PRAM_WR_VALID;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, seed;
   logic [9:0]  PRAM_WR_ADDR;
   logic [7:0]  QUICK_EVENT, QUEUE_ZERO_QUICK_EVENT, QUEUE_ONE_QUICK_EVENT;
   logic [63:0] DMA_EVENT, QUEUE_ZERO_DMA_EVENT, QUEUE_ONE_DMA_EVENT;
   logic        q_valid [2], q_ready [2], c_valid [2], c_ready [2];
   logic [31:0] q_data [2], c_data [2], n_seen [2], sum_seen [2], sum_sent [2];
   logic [31:0] regs [18];
   int          fails, n_tests;

   dcq_map dcq_map_inst (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .PRAM_WR_VALID, .PRAM_WR_ADDR, .QUICK_EVENT, .DMA_EVENT,
      .QUEUE_ZERO_DMA_EVENT, .QUEUE_ONE_DMA_EVENT, .QUEUE_ZERO_QUICK_EVENT, .QUEUE_ONE_QUICK_EVENT,
      .QUEUE_ZERO_REQ_VALID(q_valid[0]), .QUEUE_ZERO_REQ_DATA(q_data[0]),
      .QUEUE_ZERO_REQ_READY(q_ready[0]), .CTRL_ZERO_REQ_VALID(c_valid[0]),
      .CTRL_ZERO_REQ_DATA(c_data[0]), .CTRL_ZERO_REQ_READY(c_ready[0]),
      .QUEUE_ONE_REQ_VALID(q_valid[1]), .QUEUE_ONE_REQ_DATA(q_data[1]),
      .QUEUE_ONE_REQ_READY(q_ready[1]), .CTRL_ONE_REQ_VALID(c_valid[1]),
      .CTRL_ONE_REQ_DATA(c_data[1]), .CTRL_ONE_REQ_READY(c_ready[1]));

   for (genvar g = 0; g < 2; g++)
   begin : tc
      dcq_tc_model #(.SEED(32'h0000_1357 + g)) dcq_tc_model_inst (.clk(CLK), .reset(RESET),
         .req_valid(c_valid[g]), .req_data(c_data[g]), .req_ready(c_ready[g]),
         .n_seen(n_seen[g]), .sum_seen(sum_seen[g]));
   end

   initial
   begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [31:0] wmask(input logic [11:0] a);
      if (a[1:0] != 2'h0 || a > 12'h040)
         return 32'h0;
      return (a < 12'h020) ? 32'h0000_3ffc : 32'h7777_7777;
   endfunction : wmask

   task automatic results();
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge CLK);
         if (PREADY === 1'b1)
            break;
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (i == 16)
      begin
         chk("apb timeout", 0, 1);
         results();
      end
   endtask : apb

   task automatic pulse(input logic [9:0] pa, input logic [63:0] ev);
      logic [7:0]  hit, z, o;
      logic [63:0] dz, d1;
      for (int q = 0; q < 8; q++)
      begin
         hit[q] = regs[q][13:5] == {2'h0, pa[9:3]} && regs[q][4:2] == pa[2:0];
         z[q] = regs[16][q*4 +: 3] == 3'h0;
         o[q] = regs[16][q*4 +: 3] == 3'h1;
      end
      for (int c = 0; c < 64; c++)
      begin
         dz[c] = ev[c] && regs[8 + c/8][(c%8)*4 +: 3] == 3'h0;
         d1[c] = ev[c] && regs[8 + c/8][(c%8)*4 +: 3] == 3'h1;
      end
      @(posedge CLK);
      PRAM_WR_VALID <= 1'b1;
      PRAM_WR_ADDR <= pa;
      DMA_EVENT <= ev;
      @(posedge CLK);
      PRAM_WR_VALID <= 1'b0;
      DMA_EVENT <= 64'h0;
      @(negedge CLK);
      chk("quick", QUICK_EVENT, hit);
      chk("quick q0", QUEUE_ZERO_QUICK_EVENT, hit & z);
      chk("quick q1", QUEUE_ONE_QUICK_EVENT, hit & o);
      chk("dma q0", QUEUE_ZERO_DMA_EVENT, dz);
      chk("dma q1", QUEUE_ONE_DMA_EVENT, d1);
   endtask : pulse

   task automatic send(input int g);
      logic [31:0] d;
      int          i;
      sum_sent[g] = 32'h0;
      @(posedge CLK);
      for (int k = 0; k < 30; k++)
      begin
         d = rnd();
         q_data[g] <= d;
         q_valid[g] <= 1'b1;
         for (i = 0; i < 50; i++)
         begin
            @(posedge CLK);
            if (q_ready[g] === 1'b1)
               break;
         end
         sum_sent[g] ^= d;
         if (i == 50)
         begin
            chk("queue timeout", 0, 1);
            results();
         end
      end
      q_valid[g] <= 1'b0;
   endtask : send

   initial
   begin
      logic [31:0] rd, w, r;
      logic [11:0] a;
      logic        err;
      {RESET, PSEL, PENABLE, PWRITE, PRAM_WR_VALID} = 5'h10;
      {PADDR, PWDATA, PRAM_WR_ADDR, DMA_EVENT} = '0;
      q_valid = '{1'b0, 1'b0};
      q_data = '{32'h0, 32'h0};
      regs = '{default: 32'h0};
      seed = 32'h0001_6c6b;
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      pulse(10'h000, {rnd(), rnd()});
      for (int n = 0; n < 19; n++)
      begin
         a = (n == 18) ? 12'h042 : 12'(n * 4);
         apb(1'b0, a, 32'h0, rd, err);
         chk("reset value", rd, 0);
         chk("reset err", err, wmask(a) == 0);
         w = rnd();
         apb(1'b1, a, w, rd, err);
         apb(1'b0, a, 32'h0, rd, err);
         chk("readback", rd, w & wmask(a));
         chk("access err", err, wmask(a) == 0);
      end
      for (int n = 0; n < 17; n++)
      begin
         r = rnd();
         w = (n < 8) ? {20'h0, r[3:0], n[2:0], r[7:5], 2'h0} : r & 32'h1111_1111;
         apb(1'b1, 12'(n * 4), w, rd, err);
         regs[n] = w;
      end
      for (int q = 0; q < 8; q++)
         pulse({regs[q][11:5], regs[q][4:2]}, {rnd(), rnd()});
      repeat (40)
      begin
         r = rnd();
         pulse(r[9:0], {rnd(), rnd()});
      end
      w = regs[0] | 32'h0000_2000;
      apb(1'b1, 12'h000, w, rd, err);
      regs[0] = w;
      pulse({w[11:5], w[4:2]}, 64'h0);
      fork
         send(0);
         send(1);
      join
      for (int i = 0; i < 100 && !(n_seen[0] == 30 && n_seen[1] == 30); i++)
         @(posedge CLK);
      for (int g = 0; g < 2; g++)
      begin
         chk("ctrl count", n_seen[g], 30);
         chk("ctrl data", sum_seen[g], sum_sent[g]);
      end
      results();
   end
endmodule : dcq_map_test
`default_nettype wire

// ==== verif/dcq_tc_model.sv ====
// Transfer controller model taking requests with random stalls
`timescale 1ns/1ps
`default_nettype none
module dcq_tc_model #(
   parameter logic [31:0] SEED = 32'h0000_1357
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        req_valid,
   input  wire logic [31:0] req_data,
   output logic             req_ready,
   output logic      [31:0] n_seen,
   output logic      [31:0] sum_seen
);
   logic [31:0] st_r;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_r      <= SEED;
         req_ready <= 1'b0;
         n_seen    <= 32'h0;
         sum_seen  <= 32'h0;
      end
      else
      begin
         st_r      <= {st_r[30:0], st_r[31] ^ st_r[21] ^ st_r[1] ^ st_r[0]};
         req_ready <= st_r[3:2] != 2'h0;
         if (req_valid && req_ready)
         begin
            n_seen   <= n_seen + 32'h1;
            sum_seen <= sum_seen ^ req_data;
         end
      end
   end
endmodule : dcq_tc_model
`default_nettype wire
